// ### rtl/gpp_pkg.sv
// Package: addresses, bit positions and carriers of the configurable I/O port block.
package gpp_pkg;

    // ------------------------------------------------------------------
    // Port indices and register addresses
    // ------------------------------------------------------------------
    localparam int         NPORT = 4;
    localparam int         NWAKE = 2;
    localparam int         PG    = 0;
    localparam int         PL    = 1;
    localparam int         PM    = 2;
    localparam int         PN    = 3;
    localparam logic [7:0] PORT_BASE [NPORT] = '{8'hD0, 8'hD4, 8'hD8, 8'hDC};
    localparam logic [7:0] OFS_DATA    = 8'h00;
    localparam logic [7:0] OFS_CFG     = 8'h01;
    localparam logic [7:0] OFS_PIN     = 8'h02;
    localparam logic [7:0] PORT_D_ADDR = 8'hC0;
    localparam logic [7:0] N_ALT_ADDR  = 8'hC1;
    localparam logic [7:0] WK_EN_BASE  = 8'hC4;
    localparam logic [7:0] WK_EDG_BASE = 8'hC6;
    localparam logic [7:0] WK_PND_BASE = 8'hC8;

    // ------------------------------------------------------------------
    // Field positions, masks and reset values
    // ------------------------------------------------------------------
    localparam int         G_HALT_BIT   = 7;
    localparam int         G_IDLE_BIT   = 6;
    localparam int         G_CLOCK_DELAY_SELECT_BIT = 7;
    localparam int         G_ALTSK_BIT  = 6;
    localparam logic [7:0] G_GEN_MASK   = 8'h3F;
    localparam logic [7:0] G_CKO_MASK   = 8'h80;
    localparam logic [7:0] SPI_PIN_MASK = 8'h0F;
    localparam logic [3:0] SPI_DIR_MASTER = 4'h6;
    localparam logic [3:0] SPI_DIR_SLAVE  = 4'h1;
    localparam logic [7:0] ZERO8        = 8'h00;
    localparam logic [7:0] ONES8        = 8'hFF;
    localparam logic [7:0] ESS_ONE      = 8'h01;
    localparam logic [7:0] PORT_D_RESET = 8'hFF;
    localparam logic [1:0] CAN_OFF      = 2'h3;

    // ------------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpp_bus_t;

    typedef struct packed {
        logic [7:0] val;
        logic [7:0] oe_n;
        logic [7:0] pull;
    } gpp_drive_t;

    localparam gpp_drive_t DRIVE_RESET = '{val: 8'h00, oe_n: 8'hFF, pull: 8'h00};

    typedef enum logic [1:0] {
        PM_RUN  = 2'b00,
        PM_IDLE = 2'b01,
        PM_HALT = 2'b10
    } gpp_pmode_t;

    localparam int PM_IDLE_BIT = 0;
    localparam int PM_HALT_BIT = 1;

endpackage : gpp_pkg

// ### rtl/gpp_port_block.sv
// Configurable I/O ports G, L, M, N and output-only port D with wakeup and power-mode control.
module gpp_port_block (
    input  wire logic                                core_clk,
    input  wire logic                                reset,
    input  wire gpp_pkg::gpp_bus_t                   bus,
    output logic [7:0]                               rdata,
    input  wire logic [gpp_pkg::NPORT-1:0][7:0]      pins_in,
    output gpp_pkg::gpp_drive_t [gpp_pkg::NPORT-1:0] port_drive,
    output logic [7:0]                               port_d_out,
    input  wire logic                                clock_output_source,
    output logic                                     shift_clock_alt_phase,
    output logic                                     clock_delay_select,
    output logic                                     halt_mode,
    output logic                                     idle_mode,
    output logic                                     wakeup_request,
    input  wire logic                                spi_enable,
    input  wire logic                                spi_master,
    input  wire logic                                spi_miso_out,
    input  wire logic                                spi_mosi_out,
    input  wire logic                                spi_sck_out,
    input  wire logic                                spi_ss_n,
    input  wire logic [7:0]                          spi_shift,
    input  wire logic [7:0]                          m_alt_sel,
    input  wire logic [7:0]                          m_alt_dir,
    input  wire logic [7:0]                          m_alt_val,
    input  wire logic [7:0]                          m_wake_alt_sel,
    input  wire logic [6:0]                          m_wake_alt_src,
    input  wire logic                                can_wake_event,
    input  wire logic                                can_tx_drive_enable_0,
    input  wire logic                                can_tx_drive_enable_1,
    input  wire logic [1:0]                          can_tx_data,
    output logic [1:0]                               can_tx_val,
    output logic [1:0]                               can_tx_oe_n
);

    // ------------------------------------------------------------------
    // Storage and decode
    // ------------------------------------------------------------------
    logic [7:0]          cfg_reg [gpp_pkg::NPORT];
    logic [7:0]          dat_reg [gpp_pkg::NPORT];
    logic [7:0]          dir_w   [gpp_pkg::NPORT];
    logic [7:0]          val_w   [gpp_pkg::NPORT];
    logic [7:0]          pull_w  [gpp_pkg::NPORT];
    logic [7:0]          n_alt_reg;
    logic [7:0]          rd_mux;
    logic [7:0]          ess_n;
    logic [7:0]          m_sel;
    logic [7:0]          m_adir;
    logic [7:0]          m_aval;
    logic [3:0]          spi_dir;
    logic [3:0]          spi_val;
    logic [1:0][7:0]     wk_en_reg;
    logic [1:0][7:0]     wk_edg_reg;
    logic [1:0][7:0]     wk_pnd_reg;
    logic [1:0][7:0]     wk_prev_reg;
    logic [1:0][7:0]     wk_src;
    logic [1:0][7:0]     wk_hit;
    logic [1:0][7:0]     wk_pnd_next;
    logic                wake_next;
    logic                g_data_wr;
    gpp_pkg::gpp_pmode_t pm_reg;
    gpp_pkg::gpp_pmode_t pm_next;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic [7:0] o);
        return a == b + o;
    endfunction : hit

    assign g_data_wr = bus.wr && hit(bus.addr, gpp_pkg::PORT_BASE[gpp_pkg::PG], gpp_pkg::OFS_DATA);

    // ------------------------------------------------------------------
    // Port registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        for (int p = 0; p < gpp_pkg::NPORT; p++) begin
            if (reset) begin
                cfg_reg[p] <= gpp_pkg::ZERO8;
                dat_reg[p] <= gpp_pkg::ZERO8;
            end else if (bus.wr && hit(bus.addr, gpp_pkg::PORT_BASE[p], gpp_pkg::OFS_CFG)) begin
                cfg_reg[p] <= bus.wdata;
            end else if (bus.wr && hit(bus.addr, gpp_pkg::PORT_BASE[p], gpp_pkg::OFS_DATA)) begin
                // Halt and idle bits act on write and are never stored.
                dat_reg[p] <= (p == gpp_pkg::PG) ? (bus.wdata & gpp_pkg::G_GEN_MASK) : bus.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            n_alt_reg  <= gpp_pkg::ZERO8;
            port_d_out <= gpp_pkg::PORT_D_RESET;
            rdata      <= gpp_pkg::ZERO8;
        end else begin
            if (bus.wr && bus.addr == gpp_pkg::N_ALT_ADDR) begin
                n_alt_reg <= bus.wdata;
            end
            if (bus.wr && bus.addr == gpp_pkg::PORT_D_ADDR) begin
                port_d_out <= bus.wdata;
            end
            if (bus.rd) begin
                rdata <= rd_mux;
            end
        end
    end

    // Pin locations return the levels present in the read cycle.
    always_comb begin
        rd_mux = gpp_pkg::ZERO8;
        for (int p = 0; p < gpp_pkg::NPORT; p++) begin
            if (hit(bus.addr, gpp_pkg::PORT_BASE[p], gpp_pkg::OFS_DATA)) rd_mux = dat_reg[p];
            if (hit(bus.addr, gpp_pkg::PORT_BASE[p], gpp_pkg::OFS_CFG)) rd_mux = cfg_reg[p];
            if (hit(bus.addr, gpp_pkg::PORT_BASE[p], gpp_pkg::OFS_PIN)) rd_mux = pins_in[p];
        end
        for (int w = 0; w < gpp_pkg::NWAKE; w++) begin
            if (hit(bus.addr, gpp_pkg::WK_EN_BASE, 8'(w))) rd_mux = wk_en_reg[w];
            if (hit(bus.addr, gpp_pkg::WK_EDG_BASE, 8'(w))) rd_mux = wk_edg_reg[w];
            if (hit(bus.addr, gpp_pkg::WK_PND_BASE, 8'(w))) rd_mux = wk_pnd_reg[w];
        end
        if (bus.addr == gpp_pkg::N_ALT_ADDR) rd_mux = n_alt_reg;
        if (bus.addr == gpp_pkg::PORT_D_ADDR) rd_mux = port_d_out;
    end

    // ------------------------------------------------------------------
    // Pin drive selection
    // ------------------------------------------------------------------
    assign dir_w[gpp_pkg::PG]  = (cfg_reg[gpp_pkg::PG] & gpp_pkg::G_GEN_MASK) | gpp_pkg::G_CKO_MASK;
    assign val_w[gpp_pkg::PG]  = dat_reg[gpp_pkg::PG]
                               | (clock_output_source ? gpp_pkg::G_CKO_MASK : gpp_pkg::ZERO8);
    assign pull_w[gpp_pkg::PG] = ~cfg_reg[gpp_pkg::PG] & dat_reg[gpp_pkg::PG];

    assign dir_w[gpp_pkg::PL]  = cfg_reg[gpp_pkg::PL];
    assign val_w[gpp_pkg::PL]  = dat_reg[gpp_pkg::PL];
    assign pull_w[gpp_pkg::PL] = ~cfg_reg[gpp_pkg::PL] & dat_reg[gpp_pkg::PL];

    // SPI pins are, low to high: MISO, MOSI, SCK, slave select.
    assign spi_dir = spi_master ? gpp_pkg::SPI_DIR_MASTER : gpp_pkg::SPI_DIR_SLAVE;
    assign spi_val = {1'b0, spi_sck_out, spi_mosi_out, spi_miso_out};
    assign m_sel   = m_alt_sel | (spi_enable ? gpp_pkg::SPI_PIN_MASK : gpp_pkg::ZERO8);
    assign m_adir  = spi_enable ? {m_alt_dir[7:4], spi_dir} : m_alt_dir;
    assign m_aval  = spi_enable ? {m_alt_val[7:4], spi_val} : m_alt_val;
    assign dir_w[gpp_pkg::PM]  = (m_sel & m_adir) | (~m_sel & cfg_reg[gpp_pkg::PM]);
    assign val_w[gpp_pkg::PM]  = (m_sel & m_aval) | (~m_sel & dat_reg[gpp_pkg::PM]);
    assign pull_w[gpp_pkg::PM] = ~m_sel & ~cfg_reg[gpp_pkg::PM] & dat_reg[gpp_pkg::PM];

    assign ess_n = spi_ss_n ? gpp_pkg::ONES8 : ~(gpp_pkg::ESS_ONE << spi_shift[2:0]);
    // Direction stays with the configuration bits even for alternates.
    assign dir_w[gpp_pkg::PN]  = cfg_reg[gpp_pkg::PN];
    assign val_w[gpp_pkg::PN]  = (n_alt_reg & ess_n) | (~n_alt_reg & dat_reg[gpp_pkg::PN]);
    assign pull_w[gpp_pkg::PN] = ~cfg_reg[gpp_pkg::PN] & val_w[gpp_pkg::PN];

    for (genvar p = 0; p < gpp_pkg::NPORT; p++) begin : g_drive
        always_ff @(posedge core_clk) begin
            if (reset) begin
                port_drive[p] <= gpp_pkg::DRIVE_RESET;
            end else begin
                port_drive[p].val  <= val_w[p];
                port_drive[p].oe_n <= ~dir_w[p];
                port_drive[p].pull <= pull_w[p];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            can_tx_val            <= '0;
            can_tx_oe_n           <= gpp_pkg::CAN_OFF;
            shift_clock_alt_phase <= 1'b0;
            clock_delay_select    <= 1'b0;
        end else begin
            can_tx_val            <= can_tx_data;
            can_tx_oe_n           <= ~{can_tx_drive_enable_1, can_tx_drive_enable_0};
            shift_clock_alt_phase <= cfg_reg[gpp_pkg::PG][gpp_pkg::G_ALTSK_BIT];
            clock_delay_select    <= cfg_reg[gpp_pkg::PG][gpp_pkg::G_CLOCK_DELAY_SELECT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Multi-input wakeup on ports L and M
    // ------------------------------------------------------------------
    assign wk_src[0] = pins_in[gpp_pkg::PL];
    assign wk_src[1] = (m_wake_alt_sel & {can_wake_event, m_wake_alt_src})
                     | (~m_wake_alt_sel & pins_in[gpp_pkg::PM]);

    for (genvar w = 0; w < gpp_pkg::NWAKE; w++) begin : g_wake
        assign wk_hit[w] = (wk_src[w] & ~wk_prev_reg[w] & ~wk_edg_reg[w])
                         | (~wk_src[w] & wk_prev_reg[w] & wk_edg_reg[w]);
        // A new edge wins over a software clear in the same cycle.
        assign wk_pnd_next[w] = (bus.wr && hit(bus.addr, gpp_pkg::WK_PND_BASE, 8'(w)) ?
                                 bus.wdata : wk_pnd_reg[w]) | wk_hit[w];

        always_ff @(posedge core_clk) begin
            wk_prev_reg[w] <= wk_src[w];
            if (reset) begin
                wk_en_reg[w]  <= gpp_pkg::ZERO8;
                wk_edg_reg[w] <= gpp_pkg::ZERO8;
                wk_pnd_reg[w] <= gpp_pkg::ZERO8;
            end else begin
                wk_pnd_reg[w] <= wk_pnd_next[w];
                if (bus.wr && hit(bus.addr, gpp_pkg::WK_EN_BASE, 8'(w))) wk_en_reg[w] <= bus.wdata;
                if (bus.wr && hit(bus.addr, gpp_pkg::WK_EDG_BASE, 8'(w))) wk_edg_reg[w] <= bus.wdata;
            end
        end
    end

    assign wake_next = |(wk_pnd_next & wk_en_reg);

    // ------------------------------------------------------------------
    // Power mode
    // ------------------------------------------------------------------
    always_comb begin
        pm_next = pm_reg;
        case (pm_reg)
            gpp_pkg::PM_RUN: begin
                if (g_data_wr && bus.wdata[gpp_pkg::G_HALT_BIT]) pm_next = gpp_pkg::PM_HALT;
                else if (g_data_wr && bus.wdata[gpp_pkg::G_IDLE_BIT]) pm_next = gpp_pkg::PM_IDLE;
            end
            gpp_pkg::PM_IDLE, gpp_pkg::PM_HALT: begin
                if (wake_next) pm_next = gpp_pkg::PM_RUN;
            end
            default: begin
                pm_next = gpp_pkg::PM_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pm_reg         <= gpp_pkg::PM_RUN;
            wakeup_request <= 1'b0;
        end else begin
            pm_reg         <= pm_next;
            wakeup_request <= wake_next;
        end
    end

    assign halt_mode = pm_reg[gpp_pkg::PM_HALT_BIT];
    assign idle_mode = pm_reg[gpp_pkg::PM_IDLE_BIT];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_lcfg_write;
        bus.wr && bus.addr == gpp_pkg::PORT_BASE[gpp_pkg::PL] + gpp_pkg::OFS_CFG;
    endsequence
    sequence s_quiet;
        !bus.wr;
    endsequence

    a_cfg_drive: assert property (s_lcfg_write ##1 s_quiet |=>
        port_drive[gpp_pkg::PL].oe_n == ~$past(bus.wdata, 2)) else $error("L drive mismatch");
    a_g_topzero: assert property (bus.rd && bus.addr == gpp_pkg::PORT_BASE[gpp_pkg::PG] |=>
        rdata[7:6] == 2'b00) else $error("G latch top bits not zero");
    a_halt_entry: assert property (g_data_wr && bus.wdata[gpp_pkg::G_HALT_BIT] && !halt_mode
        && !idle_mode |=> halt_mode) else $error("Halt not entered");
    a_idle_entry: assert property (g_data_wr && bus.wdata[gpp_pkg::G_IDLE_BIT] && !halt_mode
        && !bus.wdata[gpp_pkg::G_HALT_BIT] && !idle_mode |=> idle_mode)
        else $error("Idle not entered");
    a_alt_phase: assert property (bus.wr && bus.addr ==
        gpp_pkg::PORT_BASE[gpp_pkg::PG] + gpp_pkg::OFS_CFG |=> ##1
        shift_clock_alt_phase == $past(bus.wdata[gpp_pkg::G_ALTSK_BIT], 2))
        else $error("Alternate phase not taken");
    // The drive registers still hold their reset value one cycle after release.
    a_g_fixed: assert property (!$past(reset) |-> port_drive[gpp_pkg::PG].oe_n[7:6] == 2'b01)
        else $error("G6 or G7 direction wrong");
    a_m_alt: assert property (m_alt_sel[4] |=>
        port_drive[gpp_pkg::PM].val[4] == $past(m_alt_val[4])) else $error("M alternate ignored");
    a_spi_master: assert property (spi_enable && spi_master |=>
        port_drive[gpp_pkg::PM].oe_n[3:0] == ~gpp_pkg::SPI_DIR_MASTER) else $error("SPI dir");
    a_spi_off: assert property (!spi_enable && m_alt_sel[3:0] == 4'h0 |=>
        port_drive[gpp_pkg::PM].oe_n[3:0] == ~$past(cfg_reg[gpp_pkg::PM][3:0]))
        else $error("M pins not released");
    a_can_wake: assert property ($rose(can_wake_event) && m_wake_alt_sel[7] &&
        $past(m_wake_alt_sel[7]) && !wk_edg_reg[1][7] |=> wk_pnd_reg[1][7])
        else $error("CAN wake lost");
    a_ess_excl: assert property ($onehot0(~ess_n) && (spi_ss_n -> ess_n == 8'hFF))
        else $error("Select extensions not exclusive");
    a_n_alt: assert property (n_alt_reg[0] |=>
        port_drive[gpp_pkg::PN].val[0] == $past(ess_n[0])) else $error("N alternate value");
    a_can_tris: assert property (!can_tx_drive_enable_0 |=> can_tx_oe_n[0])
        else $error("CAN tx 0 not released");
    a_d_preset: assert property (@(posedge core_clk) $fell(reset) |->
        port_d_out == gpp_pkg::PORT_D_RESET) else $error("Port D not preset");
    a_wk_reset: assert property (@(posedge core_clk) $fell(reset) |->
        wk_en_reg == '0 && wk_pnd_reg == '0 && wk_edg_reg == '0) else $error("Wakeup not cleared");
    a_pin_read: assert property (bus.rd && bus.addr == gpp_pkg::PORT_BASE[gpp_pkg::PL] +
        gpp_pkg::OFS_PIN |=> rdata == $past(pins_in[gpp_pkg::PL])) else $error("Pin read wrong");

endmodule : gpp_port_block

// ### test/gpp_pin_load.sv
// Board-side model of pin drivers, weak pull-ups and external loads.
module gpp_pin_load (
    input  wire gpp_pkg::gpp_drive_t [gpp_pkg::NPORT-1:0] drive,
    input  wire logic [gpp_pkg::NPORT-1:0][7:0]          ext_level,
    output logic [gpp_pkg::NPORT-1:0][7:0]               pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------------
    // A driven pin follows its driver, a released one its pull-up or the load.
    always_comb begin
        for (int p = 0; p < gpp_pkg::NPORT; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (!drive[p].oe_n[b]) begin
                    pins[p][b] = drive[p].val[b];
                end else if (drive[p].pull[b]) begin
                    pins[p][b] = 1'h1;
                end else begin
                    pins[p][b] = ext_level[p][b];
                end
            end
        end
    end
endmodule : gpp_pin_load

// ### test/gpp_port_block_tb_top.sv
// Self-checking bench for the configurable I/O port block.
module gpp_port_block_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                                     core_clk = 1'h0;
    logic                                     reset    = 1'h1;
    gpp_pkg::gpp_bus_t                        bus      = '0;
    logic [gpp_pkg::NPORT-1:0][7:0]           pins_in;
    logic [gpp_pkg::NPORT-1:0][7:0]           ext      = '0;
    gpp_pkg::gpp_drive_t [gpp_pkg::NPORT-1:0] drv;
    logic [7:0] rdata, port_d_out, c, v, x, d;
    logic [7:0] m_sel = '0, m_dir = '0, m_val = '0, m_wsel = '0, shift = '0;
    logic clock_output_pin = 1'h0, spi_en = 1'h0, spi_m = 1'h0, ss_n = 1'h1, can_wk = 1'h0;
    logic en0 = 1'h0, en1 = 1'h0, alt_ph, cdly, halt, idle, wreq;
    logic [1:0] txd = '0, txv, txo;
    logic [2:0] spi_o = '0;
    logic [7:0] pw [3] = '{8'h55, 8'hAA, 8'hFF};
    logic [7:0] em [3] = '{8'h01, 8'h02, 8'h02};
    int n_errors = 0, samples_checked = 0, cycles = 0;

    gpp_pin_load LOAD (.drive(drv), .ext_level(ext), .pins(pins_in));
    gpp_port_block DUT (
        .core_clk(core_clk), .reset(reset), .bus(bus), .rdata(rdata), .pins_in(pins_in),
        .port_drive(drv), .port_d_out(port_d_out), .clock_output_source(clock_output_pin),
        .shift_clock_alt_phase(alt_ph), .clock_delay_select(cdly), .halt_mode(halt),
        .idle_mode(idle), .wakeup_request(wreq), .spi_enable(spi_en), .spi_master(spi_m),
        .spi_miso_out(spi_o[0]), .spi_mosi_out(spi_o[1]), .spi_sck_out(spi_o[2]),
        .spi_ss_n(ss_n),
        .spi_shift(shift), .m_alt_sel(m_sel), .m_alt_dir(m_dir), .m_alt_val(m_val),
        .m_wake_alt_sel(m_wsel), .m_wake_alt_src(7'h00), .can_wake_event(can_wk),
        .can_tx_drive_enable_0(en0), .can_tx_drive_enable_1(en1), .can_tx_data(txd),
        .can_tx_val(txv), .can_tx_oe_n(txo)
    );

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Expectations and bus cycles
    // ------------------------------------------------------------------
    function automatic logic [7:0] pin_lvl(logic [7:0] cf, logic [7:0] dt, logic [7:0] ex);
        return dt | (~cf & ex);
    endfunction : pin_lvl
    function automatic logic [7:0] ess(logic sn, logic [2:0] k);
        return sn ? gpp_pkg::ONES8 : ~(gpp_pkg::ESS_ONE << k);
    endfunction : ess
    function automatic logic [7:0] ad(int p, logic [7:0] o);
        return gpp_pkg::PORT_BASE[p] + o;
    endfunction : ad
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge core_clk);
        bus <= '{rd: 1'h0, wr: 1'h1, addr: a, wdata: w};
        @(posedge core_clk);
        bus <= '0;
    endtask : wr
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        bus <= '{rd: 1'h1, wr: 1'h0, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        bus <= '0;
        #1;
        chk(nm, exp, rdata);
    endtask : rchk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic rst_chk();
        chk("port_d", gpp_pkg::PORT_D_RESET, port_d_out);
        chk("l_oe_n", gpp_pkg::ONES8, drv[gpp_pkg::PL].oe_n);
        chk("mode", 8'h00, {6'h00, halt, idle});
        rchk("g_cfg", ad(gpp_pkg::PG, gpp_pkg::OFS_CFG), 8'h00);
        rchk("wk_en", gpp_pkg::WK_EN_BASE, 8'h00);
        rchk("wk_pnd", gpp_pkg::WK_PND_BASE, 8'h00);
    endtask : rst_chk
    task automatic results();
        $display("Compared %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    initial begin
        void'($urandom(32'h1332C421));
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        tick(1);
        rst_chk();
        rchk("unmapped", 8'hB0, 8'h00);
        for (int i = 0; i < 8; i++) begin
            c = 8'($urandom);
            v = 8'($urandom);
            x = 8'($urandom);
            @(posedge core_clk);
            ext[gpp_pkg::PL] <= x;
            wr(ad(gpp_pkg::PL, gpp_pkg::OFS_CFG), c);
            wr(ad(gpp_pkg::PL, gpp_pkg::OFS_DATA), v);
            tick(1);
            chk("l_oe_n", ~c, drv[gpp_pkg::PL].oe_n);
            chk("l_pull", ~c & v, drv[gpp_pkg::PL].pull);
            chk("l_val", c & v, c & drv[gpp_pkg::PL].val);
            rchk("l_data", ad(gpp_pkg::PL, gpp_pkg::OFS_DATA), v);
            rchk("l_pin", ad(gpp_pkg::PL, gpp_pkg::OFS_PIN), pin_lvl(c, v, x));
        end
        wr(ad(gpp_pkg::PG, gpp_pkg::OFS_CFG), 8'hFF);
        tick(1);
        rchk("g_cfg", ad(gpp_pkg::PG, gpp_pkg::OFS_CFG), 8'hFF);
        chk("g_oe_n", 8'h40, drv[gpp_pkg::PG].oe_n);
        chk("g_phase", 8'h03, {6'h00, cdly, alt_ph});
        wr(ad(gpp_pkg::PL, gpp_pkg::OFS_CFG), 8'h00);
        wr(ad(gpp_pkg::PL, gpp_pkg::OFS_DATA), 8'h00);
        wr(gpp_pkg::WK_EN_BASE, 8'h01);
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            ext[gpp_pkg::PL] <= 8'h00;
            wr(gpp_pkg::WK_PND_BASE, 8'h00);
            wr(ad(gpp_pkg::PG, gpp_pkg::OFS_DATA), pw[i]);
            tick(1);
            chk("mode", em[i], {6'h00, halt, idle});
            chk("wreq", 8'h00, {7'h00, wreq});
            rchk("g_data", ad(gpp_pkg::PG, gpp_pkg::OFS_DATA), pw[i] & 8'h3F);
            @(posedge core_clk);
            ext[gpp_pkg::PL] <= 8'h01;
            tick(3);
            chk("mode", 8'h00, {6'h00, halt, idle});
            chk("wreq", 8'h01, {7'h00, wreq});
        end
        wr(gpp_pkg::WK_PND_BASE, 8'h00);
        wr(gpp_pkg::WK_EN_BASE + 8'h01, 8'h80);
        @(posedge core_clk);
        m_wsel <= 8'h80;
        ext[gpp_pkg::PM] <= 8'h80;
        tick(2);
        rchk("m_pnd", gpp_pkg::WK_PND_BASE + 8'h01, 8'h00);
        rchk("m_pin", ad(gpp_pkg::PM, gpp_pkg::OFS_PIN), 8'h80);
        chk("wreq", 8'h00, {7'h00, wreq});
        @(posedge core_clk);
        can_wk <= 1'h1;
        tick(3);
        rchk("m_pnd", gpp_pkg::WK_PND_BASE + 8'h01, 8'h80);
        chk("wreq", 8'h01, {7'h00, wreq});
        c = 8'($urandom);
        v = 8'($urandom);
        @(posedge core_clk);
        m_sel <= 8'($urandom) | 8'h10;
        m_dir <= 8'($urandom);
        m_val <= 8'($urandom);
        wr(ad(gpp_pkg::PM, gpp_pkg::OFS_CFG), c);
        wr(ad(gpp_pkg::PM, gpp_pkg::OFS_DATA), v);
        tick(1);
        x = (m_sel & m_dir) | (~m_sel & c);
        chk("m_oe_n", ~x, drv[gpp_pkg::PM].oe_n);
        chk("m_val", ((m_sel & m_val) | (~m_sel & v)) & x, drv[gpp_pkg::PM].val & x);
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            m_sel <= 8'h00;
            spi_en <= (i < 2);
            spi_m <= (i == 0);
            spi_o <= 3'($urandom);
            tick(2);
            d = {4'h0, (i == 0) ? gpp_pkg::SPI_DIR_MASTER : gpp_pkg::SPI_DIR_SLAVE};
            if (i == 2) d = {4'h0, c[3:0]};
            chk("spi_oe_n", ~d & 8'h0F, {4'h0, drv[gpp_pkg::PM].oe_n[3:0]});
            chk("spi_val", d & ((i == 2) ? v : {5'h00, spi_o}), d & drv[gpp_pkg::PM].val);
        end
        wr(ad(gpp_pkg::PN, gpp_pkg::OFS_CFG), 8'hFF);
        wr(gpp_pkg::N_ALT_ADDR, 8'hFF);
        for (int k = 0; k < 9; k++) begin
            @(posedge core_clk);
            ss_n <= (k == 8);
            shift <= {5'($urandom), 3'(k)};
            tick(2);
            chk("n_ess", ess(ss_n, shift[2:0]), drv[gpp_pkg::PN].val);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {en1, en0} <= 2'(i);
            txd <= 2'($urandom);
            clock_output_pin <= 1'($urandom);
            tick(2);
            chk("can_oe_n", {6'h00, ~2'(i)}, {6'h00, txo});
            chk("can_val", {6'h00, txd}, {6'h00, txv});
            chk("g_cko", {7'h00, clock_output_pin}, {7'h00, drv[gpp_pkg::PG].val[7]});
        end
        wr(gpp_pkg::PORT_D_ADDR, 8'h5A);
        tick(1);
        chk("port_d", 8'h5A, port_d_out);
        @(posedge core_clk);
        reset <= 1'h1;
        repeat (2) @(posedge core_clk);
        reset <= 1'h0;
        tick(1);
        rst_chk();
        results();
    end
endmodule : gpp_port_block_tb_top
